//--- sss_sequencer.sv
// supply state sequencer: powerdown, init and normal states with supply enables
// Summary of operation
// RULE1 - Stay in powerdown while the power-on reset is asserted and leave only after its release; the code enters init for two cycles after reset_i drops.
// RULE2 - In powerdown every supply enable, the reset output and both safe-state outputs are low.
// RULE3 - In init the host must communicate validly before the init timer expires, else a timeout is flagged.
// RULE4 - The init timer starts on the rising edge of the reset output.
// RULE5 - The init timer stops only after a valid frame, each enabled watchdog serviced, and three error periods or monitoring off.
// RULE6 - Entering init from powerdown turns the standby regulator on, and its software setting persists outside powerdown.
// RULE7 - In init the step-down pre-regulator and controller regulator are on, and step-up runs only if strapped.
// RULE8 - The core supply follows its strap, sampled only during power-up.
// RULE9 - Communication regulator, reference and both trackers default on in init and are each switchable by software.
// RULE10 - Entering init enables the window watchdog in triggered mode and disables the functional watchdog, both then configurable.
// RULE11 - Error monitoring defaults on in init and software may turn it off.
// RULE12 - The wake-up timer is held off in init and normal.
// RULE13 - The reset output rises in init only after all monitored supplies pass threshold, delayed by the reset delay.
// RULE14 - In init both safe-state outputs and the safe-state control stay low.
// RULE15 - In normal the reset and safe-state outputs are high and the pre-regulator and controller regulator stay on.
// RULE16 - In normal software may switch the selectable supplies, watchdogs and error monitoring and configure the wake-up timer; the code holds it off.
// RULE17 - Init moves to normal only once the init timer is stopped and a valid transition request arrives.
`timescale 1ns/10ps
`default_nettype none
module sss_sequencer
   import sss_pkg::*;
#(
   parameter int RESET_DELAY_CYC = SSS_RESET_DELAY_CYC,
   parameter int INIT_TIMEOUT_CYC = SSS_INIT_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // power-on reset and straps, asynchronous pins
   input wire logic por_active_i,
   input wire logic boost_select_strap_i,
   input wire logic core_supply_strap_i,
   // supply monitors, asynchronous
   input wire logic stby_above_undervoltage_reset_threshold_i,
   input wire logic uc_above_undervoltage_reset_threshold_i,
   input wire logic core_above_undervoltage_reset_threshold_i,
   // host activity events from spi and monitors
   input wire logic spi_valid_frame_i,
   input wire logic wwd_serviced_i,
   input wire logic fwd_serviced_i,
   input wire logic err_period_ok_i,
   input wire logic wd_reconfig_i,
   input wire logic goto_normal_req_i,
   // software configuration writes
   input wire logic cfg_we_i,
   input wire logic cfg_stby_i,
   input wire logic cfg_com_i,
   input wire logic cfg_ref_i,
   input wire logic cfg_trk1_i,
   input wire logic cfg_trk2_i,
   input wire logic cfg_wwd_i,
   input wire logic cfg_fwd_i,
   input wire logic cfg_errmon_i,
   // supply enables
   output logic stby_en_o,
   output logic buck_en_o,
   output logic boost_en_o,
   output logic uc_ldo_en_o,
   output logic com_ldo_en_o,
   output logic core_en_o,
   output logic ref_en_o,
   output logic [1:0] sensor_trackers_en_o,
   output logic wakeup_timer_en_o,
   output logic wwd_en_o,
   output logic wwd_spi_mode_o,
   output logic fwd_en_o,
   output logic errmon_en_o,
   // reset and safe state
   output logic reset_output_pin_o,
   output logic safe_state_control_o,
   output logic [1:0] safe_state_outputs_o,
   // status
   output logic init_timeout_o,
   output logic init_timer_stopped_o,
   output sss_state_t state_o
);
   logic por_s, boost_s, core_s, stby_ok, uc_ok, core_ok;
   logic [31:0] delay_cnt, next_delay_cnt;
   logic [1:0] err_cnt, next_err_cnt;
   logic spi_seen, next_spi_seen, wwd_seen, next_wwd_seen, fwd_seen, next_fwd_seen;
   logic strap_core, next_strap_core, strap_boost, next_strap_boost;
   logic rst_pin, next_rst_pin, rst_rise;
   logic stopped, next_stopped, timeout, next_timeout, stop_cond;
   logic c_stby, c_com, c_ref, c_wwd, c_fwd, c_err;
   logic [1:0] c_trk;
   logic n_stby, n_com, n_ref, n_wwd, n_fwd, n_err;
   logic [1:0] n_trk;
   logic tmr_run, tmr_exp;
   sss_state_t state, next_state;

   // pins cross into the core clock before anything reads them
   sss_sync #(.WIDTH(6)) u_sync (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .pin_i({por_active_i, boost_select_strap_i, core_supply_strap_i,
              stby_above_undervoltage_reset_threshold_i,
              uc_above_undervoltage_reset_threshold_i,
              core_above_undervoltage_reset_threshold_i}),
      .sync_o({por_s, boost_s, core_s, stby_ok, uc_ok, core_ok})
   );

   // init timer, loaded on the reset output rising edge
   sss_timer #(.WIDTH(32)) u_init_tmr (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .start_i(rst_rise), // RULE4
      .stop_i(stop_cond | (state != SSS_INIT)),
      .load_i(32'(INIT_TIMEOUT_CYC)),
      .running_o(tmr_run),
      .expired_o(tmr_exp)
   );

   assign rst_rise = next_rst_pin & ~rst_pin;
   // all three conditions together, error periods or monitor off
   assign stop_cond = tmr_run & spi_seen & (~c_wwd | wwd_seen) & (~c_fwd | fwd_seen)
                      & (~c_err | (err_cnt == 2'(SSS_ERR_PERIODS))); // RULE5

   // state machine and init bookkeeping
   always_comb begin
      next_state = state;
      next_delay_cnt = delay_cnt;
      next_rst_pin = rst_pin;
      next_spi_seen = spi_seen | spi_valid_frame_i;
      next_wwd_seen = (wwd_seen & ~wd_reconfig_i) | wwd_serviced_i;
      next_fwd_seen = (fwd_seen & ~wd_reconfig_i) | fwd_serviced_i;
      next_err_cnt = err_cnt;
      next_stopped = stopped | stop_cond;
      next_timeout = timeout | tmr_exp; // RULE3
      next_strap_core = strap_core;
      next_strap_boost = strap_boost;
      if (err_period_ok_i && err_cnt != 2'(SSS_ERR_PERIODS)) begin
         next_err_cnt = err_cnt + 2'(1);
      end
      case (state)
         SSS_POWERDOWN: begin
            next_rst_pin = 1'b0;
            next_delay_cnt = '0;
            next_spi_seen = 1'b0;
            next_wwd_seen = 1'b0;
            next_fwd_seen = 1'b0;
            next_err_cnt = '0;
            next_stopped = 1'b0;
            next_timeout = 1'b0;
            if (!por_s) begin // RULE1
               next_state = SSS_INIT;
               next_strap_core = core_s; // RULE8
               next_strap_boost = boost_s;
            end
         end
         SSS_INIT: begin
            if (stby_ok && uc_ok && (core_ok || !strap_core)) begin // RULE13
               if (delay_cnt >= 32'(RESET_DELAY_CYC)) begin
                  next_rst_pin = 1'b1;
               end else begin
                  next_delay_cnt = delay_cnt + 32'(1);
               end
            end else begin
               next_delay_cnt = '0;
               next_rst_pin = 1'b0;
            end
            if (stopped && goto_normal_req_i) begin // RULE17
               next_state = SSS_NORMAL;
            end
         end
         SSS_NORMAL: begin
            next_rst_pin = 1'b1; // RULE15
         end
         default: next_state = SSS_POWERDOWN;
      endcase
      // reset output drops together with the state, never one cycle late
      if (por_s) begin
         next_state = SSS_POWERDOWN;
         next_rst_pin = 1'b0; // RULE2
      end
   end

   // software selectable enables, defaults loaded on init entry
   always_comb begin
      n_stby = c_stby;
      n_com = c_com;
      n_ref = c_ref;
      n_trk = c_trk;
      n_wwd = c_wwd;
      n_fwd = c_fwd;
      n_err = c_err;
      if (state == SSS_POWERDOWN) begin
         n_stby = SSS_STBY_RST; // RULE6
         n_com = SSS_COM_RST; // RULE9
         n_ref = SSS_REF_RST;
         n_trk = {2{SSS_TRK_RST}};
         n_wwd = SSS_WWD_RST; // RULE10
         n_fwd = SSS_FWD_RST;
         n_err = SSS_ERRMON_RST; // RULE11
      end else if (cfg_we_i) begin // RULE16
         n_stby = cfg_stby_i;
         n_com = cfg_com_i;
         n_ref = cfg_ref_i;
         n_trk = {cfg_trk2_i, cfg_trk1_i};
         n_wwd = cfg_wwd_i;
         n_fwd = cfg_fwd_i;
         n_err = cfg_errmon_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state <= SSS_POWERDOWN;
         delay_cnt <= '0;
         rst_pin <= 1'b0;
         spi_seen <= 1'b0;
         wwd_seen <= 1'b0;
         fwd_seen <= 1'b0;
         err_cnt <= '0;
         stopped <= 1'b0;
         timeout <= 1'b0;
         strap_core <= 1'b0;
         strap_boost <= 1'b0;
         c_stby <= SSS_STBY_RST;
         c_com <= SSS_COM_RST;
         c_ref <= SSS_REF_RST;
         c_trk <= {2{SSS_TRK_RST}};
         c_wwd <= SSS_WWD_RST;
         c_fwd <= SSS_FWD_RST;
         c_err <= SSS_ERRMON_RST;
      end else begin
         state <= next_state;
         delay_cnt <= next_delay_cnt;
         rst_pin <= next_rst_pin;
         spi_seen <= next_spi_seen;
         wwd_seen <= next_wwd_seen;
         fwd_seen <= next_fwd_seen;
         err_cnt <= next_err_cnt;
         stopped <= next_stopped;
         timeout <= next_timeout;
         strap_core <= next_strap_core;
         strap_boost <= next_strap_boost;
         c_stby <= n_stby;
         c_com <= n_com;
         c_ref <= n_ref;
         c_trk <= n_trk;
         c_wwd <= n_wwd;
         c_fwd <= n_fwd;
         c_err <= n_err;
      end
   end

   // outputs decoded from state; powerdown forces every enable, the reset output and the safe-state outputs low
   always_comb begin
      logic on;
      on = (state != SSS_POWERDOWN); // RULE2
      stby_en_o = on & c_stby;
      buck_en_o = on; // RULE7
      boost_en_o = on & strap_boost;
      uc_ldo_en_o = on;
      com_ldo_en_o = on & c_com;
      core_en_o = on & strap_core;
      ref_en_o = on & c_ref;
      sensor_trackers_en_o = on ? c_trk : 2'h0;
      wakeup_timer_en_o = 1'b0; // RULE12
      wwd_en_o = on & c_wwd;
      wwd_spi_mode_o = on;
      fwd_en_o = on & c_fwd;
      errmon_en_o = on & c_err;
      reset_output_pin_o = rst_pin;
      safe_state_control_o = (state == SSS_NORMAL); // RULE14
      safe_state_outputs_o = (state == SSS_NORMAL) ? 2'h3 : 2'h0;
      init_timeout_o = timeout;
      init_timer_stopped_o = stopped;
      state_o = state;
   end

   // checks
   property p_pd_low;
      @(posedge core_clk_i) disable iff (reset_i)
      (state == SSS_POWERDOWN) |-> !reset_output_pin_o && !uc_ldo_en_o && safe_state_outputs_o == 2'b00;
   endproperty
   a_pd_low: assert property (p_pd_low) else $error("powerdown outputs not low"); // RULE2

   property p_por_hold;
      @(posedge core_clk_i) disable iff (reset_i)
      por_s |=> (state == SSS_POWERDOWN);
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("left powerdown under por"); // RULE1

   property p_normal_entry;
      @(posedge core_clk_i) disable iff (reset_i)
      (state == SSS_INIT) ##1 (state == SSS_NORMAL) |-> $past(stopped) && $past(goto_normal_req_i);
   endproperty
   a_normal_entry: assert property (p_normal_entry) else $error("normal entered without stop and request"); // RULE17

   property p_init_safe;
      @(posedge core_clk_i) disable iff (reset_i)
      (state == SSS_INIT) |-> !safe_state_control_o && safe_state_outputs_o == 2'b00;
   endproperty
   a_init_safe: assert property (p_init_safe) else $error("safe state high in init"); // RULE14

   property p_normal_high;
      @(posedge core_clk_i) disable iff (reset_i)
      (state == SSS_NORMAL) ##1 (state == SSS_NORMAL) |-> reset_output_pin_o && safe_state_outputs_o == 2'b11;
   endproperty
   a_normal_high: assert property (p_normal_high) else $error("normal outputs not high"); // RULE15

   property p_timer_start;
      @(posedge core_clk_i) disable iff (reset_i)
      $rose(reset_output_pin_o) && (state == SSS_INIT) |-> tmr_run || stopped;
   endproperty
   a_timer_start: assert property (p_timer_start) else $error("init timer not started"); // RULE4

   property p_stop_needs_spi;
      @(posedge core_clk_i) disable iff (reset_i)
      $rose(stopped) |-> $past(spi_seen) && (!$past(c_err) || $past(err_cnt) == 2'(SSS_ERR_PERIODS));
   endproperty
   a_stop_needs_spi: assert property (p_stop_needs_spi) else $error("timer stopped early"); // RULE5

   property p_wake_off;
      @(posedge core_clk_i) disable iff (reset_i)
      (state != SSS_POWERDOWN) |-> !wakeup_timer_en_o;
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake-up timer enabled"); // RULE12

   property p_init_defaults;
      @(posedge core_clk_i) disable iff (reset_i)
      (state == SSS_POWERDOWN) ##1 (state == SSS_INIT) |-> wwd_en_o && !fwd_en_o && stby_en_o && errmon_en_o;
   endproperty
   a_init_defaults: assert property (p_init_defaults) else $error("init defaults wrong"); // RULE10

   property p_timeout;
      @(posedge core_clk_i) disable iff (reset_i)
      tmr_exp && (state == SSS_INIT) |=> init_timeout_o;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout not flagged"); // RULE3
endmodule : sss_sequencer
`default_nettype wire

//--- sss_pkg.sv
// shared constants and types for the supply state sequencer
package sss_pkg;
   // operating states
   typedef enum logic [1:0] {
      SSS_POWERDOWN,
      SSS_INIT,
      SSS_NORMAL
   } sss_state_t;

   // reset delay and init timeout, in microseconds, and cycle counts at 250 MHz
   localparam int SSS_CLK_MHZ = 250;
   localparam int SSS_RESET_DELAY_US = 10;
   localparam int SSS_RESET_DELAY_CYC = SSS_RESET_DELAY_US * SSS_CLK_MHZ;
   localparam int SSS_INIT_TIMEOUT_US = 550000;
   localparam int SSS_INIT_TIMEOUT_CYC = SSS_INIT_TIMEOUT_US * SSS_CLK_MHZ;
   // error monitoring periods needed before the init timer may stop
   localparam int SSS_ERR_PERIODS = 3;

   // reset values of the software-selectable enables
   localparam logic SSS_STBY_RST = 1'b1;
   localparam logic SSS_COM_RST = 1'b1;
   localparam logic SSS_REF_RST = 1'b1;
   localparam logic SSS_TRK_RST = 1'b1;
   localparam logic SSS_WWD_RST = 1'b1;
   localparam logic SSS_FWD_RST = 1'b0;
   localparam logic SSS_ERRMON_RST = 1'b1;
endpackage : sss_pkg

//--- sss_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
`default_nettype none
module sss_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // pins and synchronised copies
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync;

   // first flop only feeds the second
   always_comb begin
      next_meta = pin_i;
      next_sync = meta;
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= next_meta;
         sync_o <= next_sync;
      end
   end
endmodule : sss_sync
`default_nettype wire

//--- sss_timer.sv
// loadable down-counter with a one-cycle expiry pulse
`timescale 1ns/10ps
`default_nettype none
module sss_timer #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // control
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic [WIDTH-1:0] load_i,
   // status
   output logic running_o,
   output logic expired_o
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic next_running;
   logic next_expired;

   // stop beats start, start reloads a running timer
   always_comb begin
      next_count = count;
      next_running = running_o;
      next_expired = 1'b0;
      if (stop_i) begin
         next_running = 1'b0;
      end else if (start_i) begin
         next_count = load_i;
         next_running = 1'b1;
      end else if (running_o) begin
         if (count <= WIDTH'(1)) begin
            next_running = 1'b0;
            next_expired = 1'b1;
            next_count = '0;
         end else begin
            next_count = count - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         count <= '0;
         running_o <= 1'b0;
         expired_o <= 1'b0;
      end else begin
         count <= next_count;
         running_o <= next_running;
         expired_o <= next_expired;
      end
   end
endmodule : sss_timer
`default_nettype wire

//--- sss_host_model.sv
// behavioural host controller model driving the sequencer's activity events
`timescale 1ns/10ps
`default_nettype none
module sss_host_model (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // commands from the bench
   input wire logic go_i,
   input wire logic [1:0] err_count_i,
   input wire logic [3:0] gap_i,
   input wire logic goto_i,
   // host activity events
   output logic spi_valid_frame_o,
   output logic wwd_serviced_o,
   output logic fwd_serviced_o,
   output logic err_period_ok_o,
   output logic goto_normal_req_o,
   output logic busy_o
);
   int n;

   // events rest low between host transactions
   initial begin
      spi_valid_frame_o = 1'h0;
      wwd_serviced_o = 1'h0;
      fwd_serviced_o = 1'h0;
      err_period_ok_o = 1'h0;
      goto_normal_req_o = 1'h0;
      busy_o = 1'h0;
   end

   // one frame with watchdog service, then error periods spaced by gap_i
   always begin
      @(posedge core_clk_i);
      if (go_i === 1'h1 && reset_i === 1'h0) begin
         #1;
         busy_o = 1'h1;
         spi_valid_frame_o = 1'h1;
         wwd_serviced_o = 1'h1;
         fwd_serviced_o = 1'h1;
         @(posedge core_clk_i);
         #1;
         spi_valid_frame_o = 1'h0;
         wwd_serviced_o = 1'h0;
         fwd_serviced_o = 1'h0;
         for (n = 0; n < err_count_i; n++) begin
            // a large gap models a slow error pin period
            repeat (gap_i) @(posedge core_clk_i);
            #1;
            err_period_ok_o = 1'h1;
            @(posedge core_clk_i);
            #1;
            err_period_ok_o = 1'h0;
         end
         busy_o = 1'h0;
      end
   end

   // transition request goes out one cycle after the bench asks for it
   always @(posedge core_clk_i) begin
      goto_normal_req_o <= #1 goto_i;
   end
endmodule : sss_host_model
`default_nettype wire

//--- sss_sequencer_bench.sv
// self-checking bench for the supply state sequencer
`timescale 1ns/10ps
`default_nettype none
module sss_sequencer_bench;
   import sss_pkg::*;
   localparam int RD = 4;
   localparam int TO = 50;
   logic core_clk_i = 1'h0;
   logic reset_i = 1'h1;
   logic por = 1'h1;
   logic boost = 1'h0;
   logic core_strap = 1'h0;
   logic stby_ok = 1'h0;
   logic uc_ok = 1'h0;
   logic core_ok = 1'h0;
   logic wd_reconfig = 1'h0;
   logic cfg_we = 1'h0;
   logic cfg_stby = 1'h0, cfg_com = 1'h0, cfg_ref = 1'h0, cfg_trk1 = 1'h0;
   logic cfg_trk2 = 1'h0, cfg_wwd = 1'h0, cfg_fwd = 1'h0, cfg_errmon = 1'h0;
   logic go = 1'h0;
   logic goto = 1'h0;
   logic [1:0] err_cnt = 2'h0;
   logic [3:0] gap = 4'h1;
   logic spi_frame, wwd_svc, fwd_svc, err_ok, goto_req, busy;
   logic stby_en, buck_en, boost_en, uc_en, com_en, core_en, ref_en, wake_en;
   logic wwd_en, wwd_mode, fwd_en, errmon_en, rst_out, safe_state_control, tmo, stopped;
   logic [1:0] trk_en, ss_out;
   sss_state_t state;
   int mismatches = 0;
   int compares = 0;
   // outputs packed for compact comparison, watchdog mode kept apart
   wire logic [16:0] outs = {stby_en, buck_en, boost_en, uc_en, com_en, core_en, ref_en, trk_en,
      wake_en, wwd_en, fwd_en, errmon_en, rst_out, safe_state_control, ss_out};

   // 250 MHz core clock
   always #2 core_clk_i = ~core_clk_i;

   sss_sequencer #(.RESET_DELAY_CYC(RD), .INIT_TIMEOUT_CYC(TO)) dut_u (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .por_active_i(por),
      .boost_select_strap_i(boost), .core_supply_strap_i(core_strap),
      .stby_above_undervoltage_reset_threshold_i(stby_ok),
      .uc_above_undervoltage_reset_threshold_i(uc_ok),
      .core_above_undervoltage_reset_threshold_i(core_ok),
      .spi_valid_frame_i(spi_frame), .wwd_serviced_i(wwd_svc), .fwd_serviced_i(fwd_svc),
      .err_period_ok_i(err_ok), .wd_reconfig_i(wd_reconfig), .goto_normal_req_i(goto_req),
      .cfg_we_i(cfg_we), .cfg_stby_i(cfg_stby), .cfg_com_i(cfg_com), .cfg_ref_i(cfg_ref),
      .cfg_trk1_i(cfg_trk1), .cfg_trk2_i(cfg_trk2), .cfg_wwd_i(cfg_wwd), .cfg_fwd_i(cfg_fwd),
      .cfg_errmon_i(cfg_errmon), .stby_en_o(stby_en), .buck_en_o(buck_en), .boost_en_o(boost_en),
      .uc_ldo_en_o(uc_en), .com_ldo_en_o(com_en), .core_en_o(core_en), .ref_en_o(ref_en),
      .sensor_trackers_en_o(trk_en), .wakeup_timer_en_o(wake_en), .wwd_en_o(wwd_en),
      .wwd_spi_mode_o(wwd_mode), .fwd_en_o(fwd_en), .errmon_en_o(errmon_en),
      .reset_output_pin_o(rst_out), .safe_state_control_o(safe_state_control), .safe_state_outputs_o(ss_out),
      .init_timeout_o(tmo), .init_timer_stopped_o(stopped), .state_o(state)
   );

   sss_host_model host_u (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .go_i(go), .err_count_i(err_cnt), .gap_i(gap),
      .goto_i(goto), .spi_valid_frame_o(spi_frame), .wwd_serviced_o(wwd_svc),
      .fwd_serviced_o(fwd_svc), .err_period_ok_o(err_ok), .goto_normal_req_o(goto_req), .busy_o(busy)
   );

   task automatic test_done();
      if (mismatches == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // inputs always change 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : tick

   task automatic power_up(input logic bst, input logic cor);
      int n = 0;
      boost = bst;
      core_strap = cor;
      por = 1'h0;
      while (state !== SSS_INIT && n < 20) begin
         tick(1);
         n++;
      end
      check(17'(state), 17'(SSS_INIT), "init entry after por release");
   endtask : power_up

   task automatic power_down();
      por = 1'h1;
      // two sync edges plus one: first cycle in powerdown
      tick(3);
      check(outs, 17'h00000, "powerdown outputs");
      check(17'(state), 17'(SSS_POWERDOWN), "powerdown state");
   endtask : power_down

   // bounded wait for the reset output, returns cycles waited
   task automatic wait_reset(output int n);
      n = 0;
      while (rst_out !== 1'h1 && n < 60) begin
         tick(1);
         n++;
      end
   endtask : wait_reset

   task automatic host(input logic [1:0] errs, input logic [3:0] g);
      int n = 0;
      err_cnt = errs;
      gap = g;
      go = 1'h1;
      tick(1);
      go = 1'h0;
      do begin
         @(negedge core_clk_i);
         n++;
      end while (busy === 1'h1 && n < 60);
      tick(1);
   endtask : host

   task automatic request_normal();
      goto = 1'h1;
      tick(1);
      goto = 1'h0;
      tick(4);
   endtask : request_normal

   task automatic cfg_write(input logic [7:0] v);
      {cfg_stby, cfg_com, cfg_ref, cfg_trk1, cfg_trk2, cfg_wwd, cfg_fwd, cfg_errmon} = v;
      cfg_we = 1'h1;
      tick(1);
      cfg_we = 1'h0;
      tick(1);
   endtask : cfg_write

   // first power-up: defaults, strap freeze, reset delay, service and normal entry
   task automatic t_first_run();
      int n;
      tick(10);
      check(17'(state), 17'(SSS_POWERDOWN), "held in powerdown");
      check(outs, 17'h00000, "powerdown outputs");
      power_up(1'h1, 1'h0);
      core_strap = 1'h1;
      tick(4);
      check(outs, 17'h1F750, "init defaults");
      check(17'(wwd_mode), 17'h1, "window watchdog mode");
      stby_ok = 1'h1;
      tick(20);
      check(17'(rst_out), 17'h0, "reset before all supplies good");
      uc_ok = 1'h1;
      wait_reset(n);
      check(17'(n >= RD + 1 && n <= RD + 5), 17'h1, "reset delay");
      host(2'h2, 4'h1);
      check(17'(stopped), 17'h0, "timer stopped with two periods");
      request_normal();
      check(17'(state), 17'(SSS_INIT), "early normal request");
      host(2'h1, 4'h3);
      tick(2);
      check(17'(stopped), 17'h1, "timer stopped");
      check(17'(tmo), 17'h0, "no timeout");
      request_normal();
      check(17'(state), 17'(SSS_NORMAL), "normal entry");
      check(outs, 17'h1F75F, "normal outputs");
      cfg_write(8'h12);
      check(outs, 17'h0E12F, "normal configuration");
   endtask : t_first_run

   // second power-up: writes refused in powerdown, core strap on, error monitoring off
   task automatic t_errmon_off();
      int n;
      power_down();
      cfg_write(8'h00);
      power_up(1'h0, 1'h1);
      tick(3);
      check(outs, 17'h1BF50, "defaults after re-entry");
      // early service, then a watchdog reconfiguration voids it
      host(2'h0, 4'h1);
      wd_reconfig = 1'h1;
      tick(1);
      wd_reconfig = 1'h0;
      tick(20);
      check(17'(rst_out), 17'h0, "reset waits for core supply");
      core_ok = 1'h1;
      wait_reset(n);
      check(17'(rst_out), 17'h1, "reset released");
      cfg_write(8'hFC);
      tick(2);
      check(17'(stopped), 17'h0, "stopped on voided watchdog service");
      host(2'h0, 4'h1);
      tick(2);
      check(17'(stopped), 17'h1, "stop with monitoring off");
   endtask : t_errmon_off

   // third power-up: no host activity, timeout flagged, state kept
   task automatic t_timeout();
      int n;
      power_down();
      power_up(1'h1, 1'h1);
      wait_reset(n);
      tick(TO - 4);
      check(17'(tmo), 17'h0, "timeout too early");
      tick(8);
      check(17'(tmo), 17'h1, "timeout flag");
      check(17'(state), 17'(SSS_INIT), "state after timeout");
      check({14'h0000, rst_out, safe_state_control, ss_out[1]}, 17'h00004, "safe state in init");
   endtask : t_timeout

   // main sequence
   initial begin
      tick(6);
      reset_i = 1'h0;
      t_first_run();
      t_errmon_off();
      t_timeout();
      test_done();
   end

   // cuts a hang short well beyond the expected run length
   initial begin
      #20000;
      mismatches++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      test_done();
   end
endmodule : sss_sequencer_bench
`default_nettype wire
